// ==== hw/sram_like_host_bus_port.sv ====
// Host bus port: strobe decode, direct FIFO modes, read snapshot and bus drive
`timescale 1ns/1ps
`default_nettype none
module sram_like_host_bus_port import host_port_pkg::*; #(
    parameter int DW = DATA_W,           // Data bus width
    parameter int CNT_W = 32             // Width of counter snapshot
) (
    input wire logic mclk,                   // System clock, 125 MHz
    input wire logic resetn,                 // Synchronous reset, active low
    input wire host_pins_s pins,             // Host bus pins
    input wire logic bus16,                  // High selects 16-bit bus mode
    output logic [DW-1:0] data_out,          // Read data to pins
    output logic [DW-1:0] data_oe,           // Output enable per data line
    output logic burst_over,                 // Normal burst exceeded its limit
    output logic csr_rd,                     // Pulse: register read done
    output logic csr_wr,                     // Pulse: register write
    output core_access_s csr_acc,            // Register write address and data
    input wire logic [DW-1:0] csr_rdata,     // Register read data, live
    input wire logic [CNT_W-1:0] counter_in, // Live counter value
    output logic [ADDR_W-1:1] csr_raddr,     // Register read address
    input wire logic [DW-1:0] rx_data_head,  // Head of receive data FIFO
    output logic rx_data_pop,                // Pulse: pop receive data FIFO
    input wire logic [DW-1:0] rx_sts_head,   // Head of receive status FIFO
    output logic rx_sts_pop,                 // Pulse: pop receive status FIFO
    input wire logic [DW-1:0] tx_sts_head,   // Head of transmit status FIFO
    output logic tx_sts_pop,                 // Pulse: pop transmit status FIFO
    output logic tx_data_push,               // Pulse: push transmit data FIFO
    output logic [DW-1:0] tx_data_word,      // Word pushed to transmit FIFO
    output logic [1:0] tx_data_lane          // Address bits 2 and 1 of push
);
    localparam logic [4:0] BURST_CNT_MAX = 5'h1f;

    logic rd_active, rd_start, rd_done;
    logic wr_active, wr_start, wr_done;
    logic [5:0] word_addr;

    // Strobe pairs for read and write
    host_cycle_detect rd_det (
        .mclk(mclk),
        .resetn(resetn),
        .select_low(pins.chip_select_low),
        .strobe_low(pins.read_strobe_low),
        .active(rd_active),
        .start(rd_start),
        .done(rd_done)
    );

    host_cycle_detect wr_det (
        .mclk(mclk),
        .resetn(resetn),
        .select_low(pins.chip_select_low),
        .strobe_low(pins.write_strobe_low),
        .active(wr_active),
        .start(wr_start),
        .done(wr_done)
    );

    assign word_addr = pins.addr[AW_MSB:AW_LSB];

    // Decode the read source; FIFO select bypasses upper decode
    function automatic read_src_e decode_rd(input logic fsel, input logic [5:0] wa);
        read_src_e s;
        s = SRC_CSR;
        if (fsel) begin
            s = SRC_RX_DATA;
        end else if (wa == AW_RX_DATA) begin
            s = SRC_RX_DATA;
        end else if (wa == AW_RX_STS) begin
            s = SRC_RX_STS;
        end else if (wa == AW_TX_STS) begin
            s = SRC_TX_STS;
        end
        return s;
    endfunction

    // Data lanes in use: the low half only in 16-bit mode
    function automatic logic [DW-1:0] lane_mask(input logic b16);
        logic [DW-1:0] m;
        m = '1;
        if (b16) begin
            m = DW'({HALF_W{1'b1}});
        end
        return m;
    endfunction

    // Read state: source, counter snapshot, burst count, drive flag
    read_src_e src_q, src_d;
    logic [CNT_W-1:0] snap_q, snap_d;
    logic [4:0] bcnt_q, bcnt_d;
    logic [DW-1:0] dout_q, dout_d;
    logic drive_q, drive_d;
    logic [ADDR_W-1:1] addr_q, addr_d;
    logic over_q, over_d;
    logic addr_move;
    logic snap_sel;

    // Counter registers are taken as the top word address
    assign snap_sel = (word_addr == AW_COUNTER);
    assign addr_move = rd_active && !rd_start && (pins.addr != addr_q);

    // Next read state and the word to present
    always_comb begin
        src_d = src_q;
        snap_d = snap_q;
        bcnt_d = bcnt_q;
        addr_d = addr_q;
        over_d = over_q;
        drive_d = rd_active;
        dout_d = dout_q;
        if (rd_start) begin
            snap_d = counter_in;
            src_d = decode_rd(pins.fifo_sel, word_addr);
            bcnt_d = 5'h00;
            addr_d = pins.addr;
            over_d = 1'b0;
        end else if (addr_move) begin
            // Each new burst address is one more access
            addr_d = pins.addr;
            src_d = decode_rd(pins.fifo_sel, word_addr);
            if (bcnt_q != BURST_CNT_MAX) begin
                bcnt_d = bcnt_q + 5'h01;
            end
            // Direct FIFO bursts have no limit
            if (!pins.fifo_sel && ({1'b0, bcnt_q} + 6'h02) >
                (bus16 ? 6'(BURST_MAX_HALVES) : 6'(BURST_MAX_WORDS))) begin
                over_d = 1'b1;
            end
        end else if (!rd_active) begin
            src_d = SRC_NONE;
        end
        unique case (src_d)
            SRC_CSR: dout_d = csr_rdata;
            SRC_RX_DATA: dout_d = rx_data_head;
            SRC_RX_STS: dout_d = rx_sts_head;
            SRC_TX_STS: dout_d = tx_sts_head;
            default: dout_d = dout_q;
        endcase
        // Counter register reads return the start-of-cycle snapshot
        if (src_d == SRC_CSR && rd_active && snap_sel) begin
            dout_d = DW'(rd_start ? counter_in : snap_q);
        end
    end

    // Register read address follows the pins
    assign csr_raddr = pins.addr;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            src_q <= SRC_NONE;
            snap_q <= '0;
            bcnt_q <= 5'h00;
            addr_q <= '0;
            over_q <= 1'b0;
            drive_q <= 1'b0;
            dout_q <= '0;
        end else begin
            src_q <= src_d;
            snap_q <= snap_d;
            bcnt_q <= bcnt_d;
            addr_q <= addr_d;
            over_q <= over_d;
            drive_q <= drive_d;
            dout_q <= dout_d;
        end
    end

    // Drive the bus only while a read is active; upper half off in 16-bit mode
    always_comb begin
        data_oe = '0;
        if (drive_q && rd_active) begin
            data_oe = lane_mask(bus16);
        end
        data_out = dout_q;
    end
    assign burst_over = over_q;

    // Completion pulses; one pop per completed read
    always_comb begin
        rx_data_pop = rd_done && (src_q == SRC_RX_DATA);
        rx_sts_pop = rd_done && (src_q == SRC_RX_STS);
        tx_sts_pop = rd_done && (src_q == SRC_TX_STS);
        csr_rd = rd_done && (src_q == SRC_CSR);
    end

    // Write capture: latch data and address while the cycle is low
    logic [DW-1:0] wdata_q, wdata_d;
    logic [ADDR_W-1:1] waddr_q, waddr_d;
    logic wfifo_q, wfifo_d;
    logic wpush_q, wpush_d;
    logic wcsr_q, wcsr_d;

    always_comb begin
        wdata_d = wdata_q;
        waddr_d = waddr_q;
        wfifo_d = wfifo_q;
        if (wr_active) begin
            // Upper half ignored in 16-bit mode
            wdata_d = DW'(pins.data_in) & lane_mask(bus16);
            waddr_d = pins.addr;
            wfifo_d = pins.fifo_sel || (pins.addr[AW_MSB:AW_LSB] == AW_TX_DATA);
        end
        wpush_d = wr_done && wfifo_q;
        wcsr_d = wr_done && !wfifo_q;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            wdata_q <= '0;
            waddr_q <= '0;
            wfifo_q <= 1'b0;
            wpush_q <= 1'b0;
            wcsr_q <= 1'b0;
        end else begin
            wdata_q <= wdata_d;
            waddr_q <= waddr_d;
            wfifo_q <= wfifo_d;
            wpush_q <= wpush_d;
            wcsr_q <= wcsr_d;
        end
    end

    // Write outputs, one cycle after strobe release
    assign tx_data_push = wpush_q;
    assign tx_data_word = wdata_q;
    assign tx_data_lane = waddr_q[AW_LSB:HALF_SEL_BIT];
    assign csr_wr = wcsr_q;
    always_comb begin
        csr_acc.addr = waddr_q;
        csr_acc.data = wdata_q;
        csr_acc.byte_en = bus16 ? (waddr_q[HALF_SEL_BIT] ? 4'hc : 4'h3) : 4'hf;
    end

    // Bus released in the same cycle a read ends
    bus_release_a: assert property (@(posedge mclk) disable iff (!resetn)
        rd_done |-> data_oe == '0) else $error("bus driven after read end");

    // Upper lines never driven in 16-bit mode
    upper_half_a: assert property (@(posedge mclk) disable iff (!resetn)
        bus16 |-> data_oe[DW-1:HALF_W] == '0) else $error("upper half driven");

    // One pop per completed read
    single_pop_a: assert property (@(posedge mclk) disable iff (!resetn)
        rx_data_pop |=> !rx_data_pop) else $error("double receive pop");

    // Pop only as a read ends
    pop_at_end_a: assert property (@(posedge mclk) disable iff (!resetn)
        rx_data_pop |-> $past(rd_active)) else $error("pop without read");

    // Push one cycle after write release
    push_timing_a: assert property (@(posedge mclk) disable iff (!resetn)
        tx_data_push |-> $past(wr_done)) else $error("push misplaced");

    // Snapshot taken at read start
    snap_take_a: assert property (@(posedge mclk) disable iff (!resetn)
        rd_start |=> snap_q == $past(counter_in)) else $error("snapshot wrong");

    // Direct FIFO reads select receive data
    direct_read_a: assert property (@(posedge mclk) disable iff (!resetn)
        rd_start && pins.fifo_sel |=> src_q == SRC_RX_DATA) else $error("bad source");

    // Direct bursts raise no overrun flag on the third cycle after read start
    direct_burst_a: assert property (@(posedge mclk) disable iff (!resetn)
        rd_start ##1 (rd_active && pins.fifo_sel)[*3] |-> !$rose(over_q))
        else $error("direct burst limited");

    // Nothing driven while no read is in progress
    idle_release_a: assert property (@(posedge mclk) disable iff (!resetn)
        !rd_active |-> data_oe == '0) else $error("bus driven while idle");

    // Full width driven from the second read cycle in 32-bit mode
    full_drive_a: assert property (@(posedge mclk) disable iff (!resetn)
        rd_active && !rd_start && !bus16 |-> data_oe == '1) else $error("word not driven");

    // Low half driven from the second read cycle in 16-bit mode
    lower_drive_a: assert property (@(posedge mclk) disable iff (!resetn)
        rd_active && !rd_start && bus16 |-> data_oe[HALF_W-1:0] == '1)
        else $error("low half not driven");

    // Upper write lines dropped in 16-bit mode
    write_upper_a: assert property (@(posedge mclk) disable iff (!resetn)
        bus16 && wr_active |=> wdata_q[DW-1:HALF_W] == '0) else $error("upper write kept");

    // Direct writes always go to the transmit FIFO
    direct_write_a: assert property (@(posedge mclk) disable iff (!resetn)
        wr_start && pins.fifo_sel |=> wfifo_q) else $error("direct write not pushed");

    // One push per completed write
    push_once_a: assert property (@(posedge mclk) disable iff (!resetn)
        tx_data_push |=> !tx_data_push) else $error("double push");

    // Status FIFOs popped once per completed read
    status_pop_a: assert property (@(posedge mclk) disable iff (!resetn)
        rx_sts_pop || tx_sts_pop |=> !rx_sts_pop && !tx_sts_pop)
        else $error("double status pop");

    // At most one read target completes at a time
    one_target_a: assert property (@(posedge mclk) disable iff (!resetn)
        $onehot0({rx_data_pop, rx_sts_pop, tx_sts_pop, csr_rd}))
        else $error("two read targets");

    // Burst limit flag cleared by each new read
    burst_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
        rd_start |=> !over_q) else $error("stale burst flag");

    // Burst limit flag only rises on a normal burst step
    burst_step_a: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(over_q) |-> $past(addr_move) && !$past(pins.fifo_sel))
        else $error("flag without step");

    // Read source held while the address stands
    src_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        rd_active && !rd_start && !addr_move |=> $stable(src_q)) else $error("source moved");
endmodule
`default_nettype wire

// ==== include/host_port_pkg.sv ====
// Package with constants and carrier types for the SRAM-like host bus port
package host_port_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    // Burst limits for normal register bursts
    localparam int BURST_MAX_WORDS = 8;
    localparam int BURST_MAX_HALVES = 16;
    // Host timing in ns and in whole clock cycles, kept by the host
    localparam int T_CSH_NS = 13;
    localparam int T_CSL_NS = 32;
    localparam int T_CSH_CYC = (T_CSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_CSL_CYC = (T_CSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Word address map (address bits 7..2), decoded when FIFO select is low
    localparam logic [5:0] AW_RX_DATA = 6'h00;
    localparam logic [5:0] AW_TX_DATA = 6'h08;
    localparam logic [5:0] AW_RX_STS = 6'h10;
    localparam logic [5:0] AW_TX_STS = 6'h12;
    localparam logic [5:0] AW_RX_STS_PEEK = 6'h11;
    localparam logic [5:0] AW_TX_STS_PEEK = 6'h13;
    localparam logic [5:0] AW_COUNTER = 6'h3f;
    localparam int AW_LSB = 2;
    localparam int AW_MSB = 7;
    localparam int HALF_SEL_BIT = 1;

    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_CSR,
        SRC_RX_DATA,
        SRC_RX_STS,
        SRC_TX_STS
    } read_src_e;

    // Host pin bundle
    typedef struct packed {
        logic chip_select_low;
        logic read_strobe_low;
        logic write_strobe_low;
        logic fifo_sel;
        logic [ADDR_W-1:1] addr;
        logic [DATA_W-1:0] data_in;
    } host_pins_s;

    // Access request towards the core register file
    typedef struct packed {
        logic [ADDR_W-1:1] addr;
        logic [DATA_W-1:0] data;
        logic [3:0] byte_en;
    } core_access_s;
endpackage

// ==== hw/host_cycle_detect.sv ====
// Strobe pair decoder that marks cycle start and completion
`timescale 1ns/1ps
`default_nettype none
module host_cycle_detect import host_port_pkg::*; (
    input wire logic mclk,           // System clock
    input wire logic resetn,         // Synchronous reset, active low
    input wire logic select_low,     // Chip select, active low
    input wire logic strobe_low,     // Read or write strobe, active low
    output logic active,             // Cycle in progress
    output logic start,              // Pulse on first cycle clock
    output logic done                // Pulse when the cycle ends
);
    logic act_q, act_d;

    // Cycle is active while both are low, in any order of edges
    always_comb begin
        act_d = !select_low && !strobe_low;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            act_q <= 1'b0;
        end else begin
            act_q <= act_d;
        end
    end

    assign active = act_d;
    assign start = act_d && !act_q;
    assign done = !act_d && act_q;
endmodule
`default_nettype wire

// ==== test/host_model.sv ====
// Host processor model that drives the strobed bus pins of the port
`timescale 1ns/1ps
`default_nettype none
module host_model import host_port_pkg::*; (
    input wire logic mclk,      // System clock, pins change on its falling edge
    output var host_pins_s pins // Bus pins driven towards the port
);
    logic last_wr = 1'b0;

    // Idle bus: select and both strobes high
    initial begin
        pins = '0;
        pins.chip_select_low = 1'b1;
        pins.read_strobe_low = 1'b1;
        pins.write_strobe_low = 1'b1;
    end

    // Open a cycle with address, FIFO select and data set at once
    task automatic begin_cyc(input logic wr, input logic fs, input logic [7:1] a,
                             input logic [31:0] d);
        @(negedge mclk);
        last_wr = wr;
        pins.fifo_sel = fs;
        pins.addr = a;
        pins.data_in = d;
        pins.chip_select_low = 1'b0;
        pins.read_strobe_low = wr;
        pins.write_strobe_low = ~wr;
    endtask

    // Next burst word, held 6 cycles so the port has time to answer
    task automatic set_addr(input logic [7:1] a);
        @(negedge mclk);
        pins.addr = a;
        repeat (6) @(negedge mclk);
    endtask

    // Release only the strobes; select stays low into the next cycle
    task automatic end_strobe();
        repeat (4) @(negedge mclk);
        pins.read_strobe_low = 1'b1;
        pins.write_strobe_low = 1'b1;
        repeat (17) @(negedge mclk);
    endtask

    // Hold the strobe, release it, then scramble the bus and keep idle
    task automatic end_cyc();
        repeat (2) @(negedge mclk);
        pins.chip_select_low = 1'b1;
        pins.read_strobe_low = 1'b1;
        pins.write_strobe_low = 1'b1;
        @(negedge mclk);
        pins.addr = ~pins.addr;
        pins.data_in = ~pins.data_in;
        repeat (last_wr ? 40 : 17) @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// ==== test/test_sram_like_host_bus_port.sv ====
// Scenario bench for the host bus port with a host model on its pins
`timescale 1ns/1ps
`default_nettype none
module test_sram_like_host_bus_port import host_port_pkg::*; ;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic bus16 = 1'b0;
    logic [31:0] counter_in = 32'h0;
    host_pins_s pins;
    logic [31:0] data_out, data_oe, csr_rdata, tx_data_word, push_word;
    logic burst_over, csr_rd, csr_wr, rx_data_pop, rx_sts_pop, tx_sts_pop, tx_data_push;
    core_access_s csr_acc, wr_acc;
    logic [7:1] csr_raddr;
    logic [1:0] tx_data_lane, push_lane;
    logic [31:0] n_rxd = 32'h0, n_rxs = 32'h0, n_txs = 32'h0, n_push = 32'h0, n_wr = 32'h0;
    logic [31:0] n_rd = 32'h0;
    int fail_count = 0;
    int samples_checked = 0;

    initial forever #4 mclk = ~mclk;
    // Register file answers with a tag and the address it is asked for
    assign csr_rdata = {16'hc5a0, 9'h0, csr_raddr};

    host_model u_host (.mclk(mclk), .pins(pins));
    sram_like_host_bus_port u_dut (
        .mclk(mclk), .resetn(resetn), .pins(pins), .bus16(bus16), .data_out(data_out),
        .data_oe(data_oe), .burst_over(burst_over), .csr_rd(csr_rd), .csr_wr(csr_wr),
        .csr_acc(csr_acc), .csr_rdata(csr_rdata), .counter_in(counter_in),
        .csr_raddr(csr_raddr), .rx_data_head(32'h1000_0000 + n_rxd),
        .rx_data_pop(rx_data_pop), .rx_sts_head(32'h2000_0000 + n_rxs),
        .rx_sts_pop(rx_sts_pop), .tx_sts_head(32'h3000_0000 + n_txs),
        .tx_sts_pop(tx_sts_pop), .tx_data_push(tx_data_push),
        .tx_data_word(tx_data_word), .tx_data_lane(tx_data_lane));

    // FIFO heads advance on each pop; last write kept for checking
    always @(posedge mclk) begin
        if (resetn) begin
            n_rxd <= n_rxd + 32'(rx_data_pop);
            n_rxs <= n_rxs + 32'(rx_sts_pop);
            n_txs <= n_txs + 32'(tx_sts_pop);
            n_push <= n_push + 32'(tx_data_push);
            n_wr <= n_wr + 32'(csr_wr);
            n_rd <= n_rd + 32'(csr_rd);
            if (tx_data_push) begin
                push_word <= tx_data_word;
                push_lane <= tx_data_lane;
            end
            if (csr_wr) begin
                wr_acc <= csr_acc;
            end
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("Checks made %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One read: enables and data checked two falling edges after start, bus freed after
    task automatic rd_one(input logic fs, input logic [7:1] a, input logic [31:0] exp);
        logic [31:0] oe;
        oe = bus16 ? 32'h0000_ffff : 32'hffff_ffff;
        u_host.begin_cyc(1'b0, fs, a, 32'h0);
        repeat (2) @(negedge mclk);
        chk("read enables", data_oe, oe);
        chk("read data", data_out & oe, exp & oe);
        u_host.end_cyc();
        chk("idle enables", data_oe, 32'h0);
    endtask

    task automatic wr_one(input logic fs, input logic [7:1] a, input logic [31:0] d);
        u_host.begin_cyc(1'b1, fs, a, d);
        repeat (2) @(negedge mclk);
        chk("write enables", data_oe, 32'h0);
        u_host.end_cyc();
    endtask

    // Register write, then direct pushes that must bypass decoding
    task automatic sc_writes();
        logic [31:0] m;
        wr_one(1'b0, 7'h0a, 32'hdead_beef);
        chk("reg writes", n_wr, 32'h1);
        chk("reg write addr", {25'h0, wr_acc.addr}, 32'h0a);
        chk("reg write data", wr_acc.data, 32'hdead_beef);
        chk("reg write lanes", {28'h0, wr_acc.byte_en}, 32'hf);
        bus16 = 1'b1;
        wr_one(1'b0, 7'h0b, 32'h1111_2222);
        chk("half write lanes", {28'h0, wr_acc.byte_en}, 32'hc);
        chk("half write data", wr_acc.data, 32'h0000_2222);
        for (int w = 0; w < 2; w++) begin
            bus16 = w[0];
            m = bus16 ? 32'h0000_ffff : 32'hffff_ffff;
            wr_one(1'b1, 7'h22, 32'h5a5a_1234 ^ 32'(w));
            chk("pushes", n_push, 32'(w + 1));
            chk("push lane", {30'h0, push_lane}, 32'h2);
            chk("push word", push_word, (32'h5a5a_1234 ^ 32'(w)) & m);
        end
        bus16 = 1'b0;
        chk("no reg write", n_wr, 32'h2);
    endtask

    // Status and data FIFO reads each pop their FIFO exactly once
    task automatic sc_status_reads();
        logic [31:0] b, r;
        r = n_rd;
        rd_one(1'b0, 7'h0a, 32'hc5a0_000a);
        chk("reg reads", n_rd, r + 1);
        b = n_rxs;
        rd_one(1'b0, 7'h20, 32'h2000_0000 + b);
        chk("rx status pops", n_rxs, b + 1);
        b = n_txs;
        rd_one(1'b0, 7'h24, 32'h3000_0000 + b);
        chk("tx status pops", n_txs, b + 1);
        b = n_rxd;
        rd_one(1'b0, 7'h00, 32'h1000_0000 + b);
        chk("rx data pops", n_rxd, b + 1);
        chk("status not reg", n_rd, r + 1);
    endtask

    // Select stays low; the read strobe alone frames two direct reads
    task automatic sc_strobe_framed();
        logic [31:0] b;
        b = n_rxd;
        u_host.begin_cyc(1'b0, 1'b1, 7'h02, 32'h0);
        u_host.end_strobe();
        chk("strobe end pops", n_rxd, b + 1);
        chk("strobe end released", data_oe, 32'h0);
        u_host.begin_cyc(1'b0, 1'b1, 7'h04, 32'h0);
        repeat (2) @(negedge mclk);
        chk("second read data", data_out, 32'h1000_0001 + b);
        u_host.end_cyc();
        chk("strobe framed pops", n_rxd, b + 2);
    endtask

    // Direct reads with upper bits aimed at status: both widths, all lanes
    task automatic sc_direct_reads();
        logic [31:0] b, s;
        s = n_rxs;
        for (int w = 0; w < 2; w++) begin
            bus16 = w[0];
            for (int l = 0; l < 4; l++) begin
                b = n_rxd;
                rd_one(1'b1, {5'b01000, l[1:0]}, 32'h1000_0000 + b);
                chk("direct pops", n_rxd, b + 1);
            end
        end
        bus16 = 1'b0;
        chk("status untouched", n_rxs, s);
    endtask

    // Counter moves after the start edge; read returns the old value
    task automatic sc_snapshot();
        counter_in = 32'h0000_0aaa;
        u_host.begin_cyc(1'b0, 1'b0, 7'h7e, 32'h0);
        @(negedge mclk);
        counter_in = 32'h0000_0bbb;
        repeat (3) @(negedge mclk);
        chk("counter snapshot", data_out, 32'h0000_0aaa);
        u_host.end_cyc();
        rd_one(1'b0, 7'h7e, 32'h0000_0bbb);
    endtask

    // Direct burst of 13 words stays legal; register burst of 9 overruns
    task automatic sc_bursts();
        u_host.begin_cyc(1'b0, 1'b1, 7'h00, 32'h0);
        for (int k = 1; k < 13; k++) begin
            u_host.set_addr(7'(2 * k));
            chk("fifo burst data", data_out, 32'h1000_0000 + n_rxd);
        end
        chk("fifo burst legal", {31'h0, burst_over}, 32'h0);
        u_host.end_cyc();
        u_host.begin_cyc(1'b0, 1'b0, 7'h40, 32'h0);
        for (int k = 1; k < 9; k++) begin
            u_host.set_addr(7'h40 + 7'(2 * k));
            chk("burst data", data_out, {16'hc5a0, 9'h0, 7'h40 + 7'(2 * k)});
            if (k == 7) chk("burst at limit", {31'h0, burst_over}, 32'h0);
        end
        chk("burst past limit", {31'h0, burst_over}, 32'h1);
        u_host.end_cyc();
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk("reset enables", data_oe, 32'h0);
        resetn = 1'b1;
        sc_writes();
        sc_status_reads();
        sc_direct_reads();
        sc_strobe_framed();
        sc_snapshot();
        sc_bursts();
        end_sim();
    end

    // Watchdog against a hung run
    initial begin
        #500000;
        fail_count++;
        end_sim();
    end
endmodule
`default_nettype wire
